// *** hw/smp_mem.sv ***
// Simple memory with a write port and a registered read port on separate clocks.
module smp_mem #(
   parameter int AW = 7,
   parameter int DW = 8
) (
   // Write port
   input wire logic wclk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [DW-1:0] wdata_i,
   // Read port
   input wire logic rclk_i,
   input wire logic re_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [DW-1:0] rdata_o
);

   logic [DW-1:0] mem [2**AW];

   // Writes land on the write clock.
   always_ff @(posedge wclk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // Reads are registered; the protocol keeps writes away while a read is in flight.
   always_ff @(posedge rclk_i) begin
      if (re_i) begin
         rdata_o <= mem[raddr_i];
      end
   end

endmodule : smp_mem

// *** hw/smp_pkg.sv ***
// Shared constants and types for the serial memory programming block.
package smp_pkg;

   // Instruction opcodes (first byte) and second-byte keys.
   localparam logic [7:0] OP_ENABLE = 8'hAC;
   localparam logic [7:0] ENABLE_KEY = 8'h53;
   localparam logic [7:0] ERASE_KEY = 8'h80;
   localparam logic [7:0] OP_POLL = 8'hF0;
   localparam logic [7:0] OP_LOAD_EXT = 8'h4D;
   localparam logic [7:0] OP_LOAD_HI = 8'h48;
   localparam logic [7:0] OP_LOAD_LO = 8'h40;
   localparam logic [7:0] OP_READ_HI = 8'h28;
   localparam logic [7:0] OP_READ_LO = 8'h20;
   localparam logic [7:0] OP_READ_EE = 8'hA0;
   localparam logic [7:0] OP_WRITE_PAGE = 8'h4C;
   localparam logic [7:0] OP_WRITE_EE = 8'hC0;

   // Data values.
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] IDLE_BYTE = 8'h00;
   localparam logic [6:0] POLL_PAD = 7'h00;

   // Frame layout: 32 bits, four bytes, counted by a 5-bit bit counter.
   localparam int FRAME_BITS = 32;
   localparam int CNT_W = 5;
   localparam logic [4:0] ECHO_SLOT = 5'h10;
   localparam logic [4:0] READ_SLOT = 5'h18;
   localparam logic [4:0] ADDR_DONE = 5'h17;
   localparam logic [4:0] FRAME_DONE = 5'h1F;

   // Memory geometry defaults (word addresses for flash, byte addresses for EEPROM).
   localparam int PAGE_AW = 7;
   localparam int FLASH_AW_DEF = 17;
   localparam int EE_AW_DEF = 12;
   localparam int ADDR_FULL_W = 24;
   localparam int WAIT_W = 24;

   // Minimum wait times as printed, and the cycle counts derived from them.
   localparam real MCLK_PERIOD_NS = 4.0;
   localparam real NS_PER_MS = 1.0e6;
   localparam real FLASH_PAGE_WAIT_MS = 4.5;
   localparam real EEPROM_BYTE_WAIT_MS = 9.0;
   localparam real ERASE_WAIT_MS = 9.0;
   localparam int FLASH_PAGE_WAIT_CYC = int'($ceil(FLASH_PAGE_WAIT_MS * NS_PER_MS / MCLK_PERIOD_NS));
   localparam int EEPROM_BYTE_WAIT_CYC = int'($ceil(EEPROM_BYTE_WAIT_MS * NS_PER_MS / MCLK_PERIOD_NS));
   localparam int ERASE_WAIT_CYC = int'($ceil(ERASE_WAIT_MS * NS_PER_MS / MCLK_PERIOD_NS));

   // One complete instruction as handed from the link to the core.
   typedef struct packed {
      logic [7:0] op;
      logic [7:0] arg_hi;
      logic [7:0] arg_lo;
      logic [7:0] data;
      logic [7:0] ext;
   } smp_cmd_type;

   // Programming engine states.
   typedef enum logic [1:0] {
      SMP_IDLE,
      SMP_COPY,
      SMP_ERASE,
      SMP_WAIT
   } smp_state_type;

endpackage : smp_pkg

// *** hw/smp_sync.sv ***
// Three-stage synchroniser that accepts a new value once stages two and three agree.
module smp_sync #(
   parameter int W = 1
) (
   // Destination clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Asynchronous input and synchronised output
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   // Stage one feeds stage two only, so a metastable value never reaches a gate.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= d_i;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // The output moves only when two settled stages agree.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_o <= '0;
      end else if (stage2 == stage3) begin
         q_o <= stage3;
      end
   end

endmodule : smp_sync

// *** hw/smp_top.sv ***
// Device-side serial programming engine for flash and EEPROM arrays.
//
// Functional notes
// - Link uses serial clock in, serial data in and serial data out.
// - Link works only while reset pin is low; enable instruction must come first.
// - Incoming serial data is sampled on the rising serial clock edge.
// - Outgoing serial data changes on the falling serial clock edge.
// - Second byte of enable echoes out while the third byte shifts in.
// - Flash is written per page; loads carry seven address bits and data.
// - Extended address byte is kept until the next load of it.
// - EEPROM byte write erases then writes one addressed byte by itself; the code simply overwrites the byte in one write.
// - Chip erase fills every flash and EEPROM location with FF.
// - Reads return addressed data; flash upper address uses stored extended byte.
// - Releasing reset high ends programming and returns to normal operation.
// - Busy poll returns bit zero high while an operation is pending.
module smp_top #(
   parameter int FLASH_AW = smp_pkg::FLASH_AW_DEF,
   parameter int EE_AW = smp_pkg::EE_AW_DEF,
   parameter int FLASH_WAIT_CYC = smp_pkg::FLASH_PAGE_WAIT_CYC,
   parameter int EEPROM_WAIT_CYC = smp_pkg::EEPROM_BYTE_WAIT_CYC,
   parameter int ERASE_WAIT_CYC = smp_pkg::ERASE_WAIT_CYC
) (
   // System clock and reset
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // Device reset pin, high means normal operation
   input wire logic rst_pin_i,
   // Serial programming link
   input wire logic sck_i,
   input wire logic serial_data_in_i,
   output logic serial_data_out_o,
   // Engine status
   output logic ready_busy_indicator_o
);

   localparam int SWEEP_AW = (FLASH_AW > EE_AW) ? FLASH_AW : EE_AW;

   // Refuse geometries and wait counts that the address fields or counters cannot hold.
   if (FLASH_AW <= smp_pkg::PAGE_AW || FLASH_AW > smp_pkg::ADDR_FULL_W) begin : g_bad_flash
      $error("FLASH_AW out of range");
   end
   if (EE_AW < 1 || EE_AW > 16) begin : g_bad_ee
      $error("EE_AW out of range");
   end
   if (FLASH_WAIT_CYC < 1 || EEPROM_WAIT_CYC < 1 || ERASE_WAIT_CYC < 1 ||
       FLASH_WAIT_CYC >= 2**smp_pkg::WAIT_W || EEPROM_WAIT_CYC >= 2**smp_pkg::WAIT_W ||
       ERASE_WAIT_CYC >= 2**smp_pkg::WAIT_W) begin : g_bad_wait
      $error("Wait count out of range");
   end

   // Resets.
   logic [1:0] rst_pipe;
   logic rst_n;
   logic link_rst_n;

   // The core reset is released through two flip-flops on the system clock.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'h1};
      end
   end
   assign rst_n = rst_pipe[1];

   // The link only lives while the reset pin is low; the programmer moves the pin with the
   // serial clock parked low, so the release needs no edge of its own.
   assign link_rst_n = arst_n_i & ~rst_pin_i;

   // Link domain: receive shifter and bit counter.
   logic [smp_pkg::CNT_W-1:0] bit_cnt;
   logic [smp_pkg::FRAME_BITS-1:0] rx_shift;
   logic [smp_pkg::FRAME_BITS-1:0] rx_next;
   logic frame_done;
   logic addr_done;

   assign rx_next = {rx_shift[smp_pkg::FRAME_BITS-2:0], serial_data_in_i};
   assign frame_done = (bit_cnt == smp_pkg::FRAME_DONE);
   assign addr_done = (bit_cnt == smp_pkg::ADDR_DONE);

   // Data in is taken on the rising edge, most significant bit first.
   always_ff @(posedge sck_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         bit_cnt <= '0;
         rx_shift <= '0;
      end else begin
         bit_cnt <= bit_cnt + 5'h1;
         rx_shift <= rx_next;
      end
   end

   // Field views of a just-completed frame and of a just-completed address.
   logic [7:0] f_op;
   logic [7:0] f_hi;
   logic [7:0] f_lo;
   logic [7:0] f_data;
   logic [7:0] a_op;
   logic [7:0] a_hi;
   logic [7:0] a_lo;

   assign f_op = rx_next[31:24];
   assign f_hi = rx_next[23:16];
   assign f_lo = rx_next[15:8];
   assign f_data = rx_next[7:0];
   assign a_op = rx_next[23:16];
   assign a_hi = rx_next[15:8];
   assign a_lo = rx_next[7:0];

   // Link domain: enable latch and extended address.
   logic prog_en;
   logic [7:0] ext_addr;

   // Nothing but the enable instruction is honoured until enable has been seen.
   always_ff @(posedge sck_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         prog_en <= 1'h0;
      end else if (frame_done && f_op == smp_pkg::OP_ENABLE && f_hi == smp_pkg::ENABLE_KEY) begin
         prog_en <= 1'h1;
      end
   end

   // The extended address stays until it is loaded again, across pages and reads.
   always_ff @(posedge sck_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         ext_addr <= '0;
      end else if (frame_done && prog_en && f_op == smp_pkg::OP_LOAD_EXT) begin
         ext_addr <= f_lo;
      end
   end

   // Link domain: instruction hand-over to the core.
   smp_pkg::smp_cmd_type cmd_hold;
   logic cmd_tgl;
   logic fwd;

   // Only instructions that change memory travel to the core.
   assign fwd = frame_done && prog_en &&
                (f_op == smp_pkg::OP_LOAD_LO || f_op == smp_pkg::OP_LOAD_HI ||
                 f_op == smp_pkg::OP_WRITE_PAGE || f_op == smp_pkg::OP_WRITE_EE ||
                 (f_op == smp_pkg::OP_ENABLE && f_hi == smp_pkg::ERASE_KEY));

   // The word is held for a whole frame and announced by a toggle. These flops are cleared
   // only by the system reset, so a reset pin pulse never fakes an event in the core.
   always_ff @(posedge sck_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cmd_hold <= '0;
         cmd_tgl <= 1'h0;
      end else if (fwd) begin
         cmd_hold <= '{op: f_op, arg_hi: f_hi, arg_lo: f_lo, data: f_data, ext: ext_addr};
         cmd_tgl <= ~cmd_tgl;
      end
   end

   // Link domain: read path and outgoing shifter.
   logic [smp_pkg::ADDR_FULL_W-1:0] flash_rfull;
   logic [15:0] ee_rfull;
   logic rd_en;
   logic [7:0] flash_lo_q;
   logic [7:0] flash_hi_q;
   logic [7:0] ee_q;
   logic busy_s;
   logic [7:0] read_byte;
   logic [7:0] tx;

   // Flash upper address comes from the stored extended byte, not from the read itself.
   assign flash_rfull = {ext_addr, a_hi, a_lo};
   assign ee_rfull = {a_hi, a_lo};
   assign rd_en = addr_done && prog_en;

   // Core busy level brought into the link clock for the poll answer.
   smp_sync #(
      .W(1)
   ) u_busy_sync (
      .clk_i(sck_i),
      .rst_n_i(link_rst_n),
      .d_i(~ready_busy_indicator_o),
      .q_o(busy_s)
   );

   // Byte returned during the fourth byte, chosen by the opcode already received.
   always_comb begin
      read_byte = smp_pkg::IDLE_BYTE;
      if (prog_en) begin
         case (rx_shift[23:16])
            smp_pkg::OP_READ_LO: read_byte = flash_lo_q;
            smp_pkg::OP_READ_HI: read_byte = flash_hi_q;
            smp_pkg::OP_READ_EE: read_byte = ee_q;
            smp_pkg::OP_POLL: read_byte = {smp_pkg::POLL_PAD, busy_s};
            default: read_byte = smp_pkg::IDLE_BYTE;
         endcase
      end
   end

   // Data out moves on the falling edge so it is settled before the next rising edge.
   always_ff @(negedge sck_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         tx <= smp_pkg::IDLE_BYTE;
      end else if (bit_cnt == smp_pkg::ECHO_SLOT) begin
         tx <= rx_shift[7:0];
      end else if (bit_cnt == smp_pkg::READ_SLOT) begin
         tx <= read_byte;
      end else begin
         tx <= {tx[6:0], 1'h0};
      end
   end
   assign serial_data_out_o = tx[7];

   // Core domain: instruction arrival.
   logic tgl_s;
   logic tgl_seen;
   logic cmd_new;

   smp_sync #(
      .W(1)
   ) u_cmd_sync (
      .clk_i(mclk_i),
      .rst_n_i(rst_n),
      .d_i(cmd_tgl),
      .q_o(tgl_s)
   );

   // A toggle edge marks a new held word; the word itself is stable by then.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         tgl_seen <= 1'h0;
      end else begin
         tgl_seen <= tgl_s;
      end
   end
   assign cmd_new = (tgl_s != tgl_seen);

   // Core domain: programming engine.
   smp_pkg::smp_state_type state;
   logic [SWEEP_AW-1:0] sweep;
   logic [smp_pkg::WAIT_W-1:0] wait_cnt;
   logic [FLASH_AW-smp_pkg::PAGE_AW-1:0] page_base;
   logic [smp_pkg::ADDR_FULL_W-1:0] page_full;
   logic copy_vld;
   logic [smp_pkg::PAGE_AW-1:0] copy_idx;
   logic idle_cmd;
   logic is_erase;
   logic op_start;

   assign idle_cmd = cmd_new && (state == smp_pkg::SMP_IDLE);
   assign is_erase = (cmd_hold.op == smp_pkg::OP_ENABLE) && (cmd_hold.arg_hi == smp_pkg::ERASE_KEY);
   // Only writes and erase start an operation; page loads never make the engine busy.
   assign op_start = idle_cmd && (cmd_hold.op == smp_pkg::OP_WRITE_PAGE ||
                                  cmd_hold.op == smp_pkg::OP_WRITE_EE || is_erase);
   assign page_full = {cmd_hold.ext, cmd_hold.arg_hi, cmd_hold.arg_lo};

   // Instructions that arrive while busy are dropped; the programmer must poll or wait.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         state <= smp_pkg::SMP_IDLE;
         sweep <= '0;
         wait_cnt <= '0;
         page_base <= '0;
      end else begin
         case (state)
            smp_pkg::SMP_IDLE: begin
               sweep <= '0;
               if (idle_cmd && cmd_hold.op == smp_pkg::OP_WRITE_PAGE) begin
                  page_base <= page_full[FLASH_AW-1:smp_pkg::PAGE_AW];
                  state <= smp_pkg::SMP_COPY;
               end else if (idle_cmd && cmd_hold.op == smp_pkg::OP_WRITE_EE) begin
                  wait_cnt <= smp_pkg::WAIT_W'(EEPROM_WAIT_CYC);
                  state <= smp_pkg::SMP_WAIT;
               end else if (idle_cmd && is_erase) begin
                  state <= smp_pkg::SMP_ERASE;
               end
            end
            smp_pkg::SMP_COPY: begin
               sweep <= sweep + 1'h1;
               if (sweep[smp_pkg::PAGE_AW-1:0] == '1) begin
                  wait_cnt <= smp_pkg::WAIT_W'(FLASH_WAIT_CYC);
                  state <= smp_pkg::SMP_WAIT;
               end
            end
            smp_pkg::SMP_ERASE: begin
               sweep <= sweep + 1'h1;
               if (&sweep) begin
                  wait_cnt <= smp_pkg::WAIT_W'(ERASE_WAIT_CYC);
                  state <= smp_pkg::SMP_WAIT;
               end
            end
            smp_pkg::SMP_WAIT: begin
               wait_cnt <= wait_cnt - 1'h1;
               if (wait_cnt <= smp_pkg::WAIT_W'(1)) begin
                  state <= smp_pkg::SMP_IDLE;
               end
            end
            default: begin
               state <= smp_pkg::SMP_IDLE;
            end
         endcase
      end
   end

   // Page copy is pipelined one cycle behind the buffer read.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         copy_vld <= 1'h0;
         copy_idx <= '0;
      end else begin
         copy_vld <= (state == smp_pkg::SMP_COPY);
         copy_idx <= sweep[smp_pkg::PAGE_AW-1:0];
      end
   end

   // Ready is registered so the link sees a clean level.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ready_busy_indicator_o <= 1'h1;
      end else begin
         ready_busy_indicator_o <= (state == smp_pkg::SMP_IDLE) && !copy_vld && !op_start;
      end
   end

   // Core domain: memory write controls.
   logic pbuf_lo_we;
   logic pbuf_hi_we;
   logic [7:0] pbuf_lo_q;
   logic [7:0] pbuf_hi_q;
   logic flash_we;
   logic [FLASH_AW-1:0] flash_waddr;
   logic [7:0] flash_lo_wd;
   logic [7:0] flash_hi_wd;
   logic ee_we;
   logic [EE_AW-1:0] ee_waddr;
   logic [7:0] ee_wd;
   logic [15:0] ee_cmd_full;

   // Each load fills one byte lane of one page-buffer word.
   assign pbuf_lo_we = idle_cmd && cmd_hold.op == smp_pkg::OP_LOAD_LO;
   assign pbuf_hi_we = idle_cmd && cmd_hold.op == smp_pkg::OP_LOAD_HI;

   // Flash takes copy data, or erased bytes while sweeping.
   assign flash_we = copy_vld || (state == smp_pkg::SMP_ERASE);
   assign flash_waddr = copy_vld ? {page_base, copy_idx} : sweep[FLASH_AW-1:0];
   assign flash_lo_wd = copy_vld ? pbuf_lo_q : smp_pkg::ERASED_BYTE;
   assign flash_hi_wd = copy_vld ? pbuf_hi_q : smp_pkg::ERASED_BYTE;

   // An EEPROM byte is simply overwritten; the old value never shows through.
   assign ee_cmd_full = {cmd_hold.arg_hi, cmd_hold.arg_lo};
   assign ee_we = (idle_cmd && cmd_hold.op == smp_pkg::OP_WRITE_EE) ||
                  (state == smp_pkg::SMP_ERASE && (sweep >> EE_AW) == '0);
   assign ee_waddr = (state == smp_pkg::SMP_ERASE) ? sweep[EE_AW-1:0] : ee_cmd_full[EE_AW-1:0];
   assign ee_wd = (state == smp_pkg::SMP_ERASE) ? smp_pkg::ERASED_BYTE : cmd_hold.data;

   // Page buffer, low and high lanes.
   smp_mem #(
      .AW(smp_pkg::PAGE_AW),
      .DW(8)
   ) u_pbuf_lo (
      .wclk_i(mclk_i),
      .we_i(pbuf_lo_we),
      .waddr_i(cmd_hold.arg_lo[smp_pkg::PAGE_AW-1:0]),
      .wdata_i(cmd_hold.data),
      .rclk_i(mclk_i),
      .re_i(state == smp_pkg::SMP_COPY),
      .raddr_i(sweep[smp_pkg::PAGE_AW-1:0]),
      .rdata_o(pbuf_lo_q)
   );

   smp_mem #(
      .AW(smp_pkg::PAGE_AW),
      .DW(8)
   ) u_pbuf_hi (
      .wclk_i(mclk_i),
      .we_i(pbuf_hi_we),
      .waddr_i(cmd_hold.arg_lo[smp_pkg::PAGE_AW-1:0]),
      .wdata_i(cmd_hold.data),
      .rclk_i(mclk_i),
      .re_i(state == smp_pkg::SMP_COPY),
      .raddr_i(sweep[smp_pkg::PAGE_AW-1:0]),
      .rdata_o(pbuf_hi_q)
   );

   // Flash array lanes; reads run on the link clock and never overlap a write by protocol.
   smp_mem #(
      .AW(FLASH_AW),
      .DW(8)
   ) u_flash_lo (
      .wclk_i(mclk_i),
      .we_i(flash_we),
      .waddr_i(flash_waddr),
      .wdata_i(flash_lo_wd),
      .rclk_i(sck_i),
      .re_i(rd_en),
      .raddr_i(flash_rfull[FLASH_AW-1:0]),
      .rdata_o(flash_lo_q)
   );

   smp_mem #(
      .AW(FLASH_AW),
      .DW(8)
   ) u_flash_hi (
      .wclk_i(mclk_i),
      .we_i(flash_we),
      .waddr_i(flash_waddr),
      .wdata_i(flash_hi_wd),
      .rclk_i(sck_i),
      .re_i(rd_en),
      .raddr_i(flash_rfull[FLASH_AW-1:0]),
      .rdata_o(flash_hi_q)
   );

   // EEPROM array.
   smp_mem #(
      .AW(EE_AW),
      .DW(8)
   ) u_eeprom (
      .wclk_i(mclk_i),
      .we_i(ee_we),
      .waddr_i(ee_waddr),
      .wdata_i(ee_wd),
      .rclk_i(sck_i),
      .re_i(rd_en),
      .raddr_i(ee_rfull[EE_AW-1:0]),
      .rdata_o(ee_q)
   );

endmodule : smp_top

// *** test/smp_prog_model.sv ***
// Behavioural model of the external programmer on the serial link.
module smp_prog_model (
   // Link lines
   output logic sck_o,
   output logic sdi_o,
   input wire logic sdo_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // Clock parks low from power-up so no stray edge reaches the link.
   initial begin
      sck_o = 1'b0;
      sdi_o = 1'b0;
   end
   // Shifts one whole frame; 24 ns phases are six core cycles each.
   task automatic frame(input logic [31:0] cmd, output logic [31:0] resp);
      for (int i = 31; i >= 0; i--) begin
         sdi_o = cmd[i];
         #24;
         resp[i] = sdo_i;
         sck_o = 1'b1;
         #24;
         sck_o = 1'b0;
      end
      // Released line shows the inverse, so a stale bit is never read as valid.
      sdi_o = ~cmd[0];
   endtask : frame
endmodule : smp_prog_model

// *** test/smp_top_asserts.sv ***
// Port-level checks for the serial programming block.
module smp_top_asserts (
   // Clock and resets
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic rst_pin_i,
   // Link and status
   input wire logic sck_i,
   input wire logic serial_data_in_i,
   input wire logic serial_data_out_o,
   input wire logic ready_busy_indicator_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);
   // Every engine wait in the bench is at least 300 cycles, so eight is a safe floor.
   sequence s_busy_hold;
      !ready_busy_indicator_o [*8];
   endsequence
   sequence s_ready_back;
      ##[1:1000] ready_busy_indicator_o;
   endsequence
   property p_out_on_fall;
      $changed(serial_data_out_o) |-> $fell(sck_i);
   endproperty
   a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off a fall");
   property p_hold_at_rise;
      $rose(sck_i) |-> $stable(serial_data_out_o);
   endproperty
   a_hold_at_rise: assert property (p_hold_at_rise) else $error("output moved on a rise");
   property p_hold_high;
      sck_i && $past(sck_i) |-> $stable(serial_data_out_o);
   endproperty
   a_hold_high: assert property (p_hold_high) else $error("output moved while high");
   property p_hold_low;
      !sck_i && !$past(sck_i) |-> $stable(serial_data_out_o);
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("output moved while low");
   property p_quiet_normal;
      rst_pin_i |-> !serial_data_out_o;
   endproperty
   a_quiet_normal: assert property (p_quiet_normal) else $error("output active in normal mode");
   property p_busy_min;
      $fell(ready_busy_indicator_o) |-> s_busy_hold;
   endproperty
   a_busy_min: assert property (p_busy_min) else $error("busy too short");
   property p_busy_bounded;
      $fell(ready_busy_indicator_o) |-> s_ready_back;
   endproperty
   a_busy_bounded: assert property (p_busy_bounded) else $error("busy never ended");
   property p_busy_in_prog;
      $fell(ready_busy_indicator_o) |-> !rst_pin_i;
   endproperty
   a_busy_in_prog: assert property (p_busy_in_prog) else $error("busy outside programming");
endmodule : smp_top_asserts

bind smp_top smp_top_asserts u_chk (.mclk_i, .arst_n_i, .rst_pin_i, .sck_i, .serial_data_in_i,
   .serial_data_out_o, .ready_busy_indicator_o);

// *** test/test_smp_top.sv ***
// Self-checking bench for the serial programming block.
module test_smp_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic rst_pin_i = 1'b1;
   logic sck, sdi, sdo, rdy;
   int n_errors = 0;
   int checked = 0;
   logic [31:0] r;
   always #2 mclk_i = ~mclk_i;
   // Flash and EEPROM waits outlast one poll frame and erase adds a 512-cycle sweep to its wait, so a poll sent at once still finds the engine busy.
   smp_top #(.FLASH_AW(9), .EE_AW(8), .FLASH_WAIT_CYC(400), .EEPROM_WAIT_CYC(400),
      .ERASE_WAIT_CYC(300)) dut (.mclk_i, .arst_n_i, .rst_pin_i, .sck_i(sck),
      .serial_data_in_i(sdi), .serial_data_out_o(sdo), .ready_busy_indicator_o(rdy));
   smp_prog_model prog (.sck_o(sck), .sdi_o(sdi), .sdo_i(sdo));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Sends a command, then checks a poll reports busy at once and reports idle once ready returns.
   task automatic op_wait(input logic [31:0] cmd);
      int n;
      prog.frame(cmd, r);
      n = 0;
      while (rdy !== 1'b0 && n < 50) begin
         @(posedge mclk_i);
         n++;
      end
      @(posedge mclk_i);
      #1;
      prog.frame(32'hF000_0000, r);
      check(r[0], 1'b1);
      n = 0;
      while (rdy !== 1'b1 && n < 3000) begin
         @(posedge mclk_i);
         n++;
      end
      @(posedge mclk_i);
      #1;
      prog.frame(32'hF000_0000, r);
      check(r[0], 1'b0);
   endtask : op_wait
   task automatic rd(input logic [31:0] cmd, input logic [7:0] exp);
      prog.frame(cmd, r);
      check(r[7:0], exp);
   endtask : rd
   task automatic t_locked;
      rst_pin_i = 1'b0;
      #100;
      prog.frame(32'hC000_07A5, r);
      #200;
      check(rdy, 1'b1);
      rd(32'hA000_0700, 8'h00);
      $display("t_locked done");
   endtask : t_locked
   task automatic t_enable;
      prog.frame(32'hAC53_0000, r);
      check(r[15:8], 8'h53);
      check(r[31:16], 16'h0000);
      $display("t_enable done");
   endtask : t_enable
   task automatic t_erase;
      op_wait(32'hAC80_0000);
      rd(32'h2000_0300, 8'hFF);
      rd(32'hA000_0700, 8'hFF);
      $display("t_erase done");
   endtask : t_erase
   task automatic t_page;
      prog.frame(32'h4D00_0000, r);
      prog.frame(32'h4000_053C, r);
      prog.frame(32'h4800_05C3, r);
      op_wait(32'h4C00_0000);
      rd(32'h2000_0500, 8'h3C);
      rd(32'h2800_0500, 8'hC3);
      $display("t_page done");
   endtask : t_page
   // The second write sets bits the first cleared, proving the old value never shows through.
   task automatic t_eeprom;
      op_wait(32'hC000_075A);
      rd(32'hA000_0700, 8'h5A);
      op_wait(32'hC000_0705);
      rd(32'hA000_0700, 8'h05);
      $display("t_eeprom done");
   endtask : t_eeprom
   task automatic t_exit;
      rst_pin_i = 1'b1;
      #200;
      check(sdo, 1'b0);
      rst_pin_i = 1'b0;
      #100;
      rd(32'hA000_0700, 8'h00);
      $display("t_exit done");
   endtask : t_exit
   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (8) @(posedge mclk_i);
      #1 arst_n_i = 1'b1;
      #24;
      t_locked();
      t_enable();
      t_erase();
      t_page();
      t_eeprom();
      t_exit();
      tally_and_finish();
   end
   initial begin
      #100000;
      n_errors++;
      tally_and_finish();
   end
endmodule : test_smp_top
